/* hdl/twb_slave.sv */
// Two-wire bus slave end: conditions, framing, acknowledge, stretching.
// Assumes the bus interface resolves open-drain levels with pull-ups.
//
// How it works
// - Lines only pulled low or released
// - START: data falls while clock high
// - STOP: data rises while clock high
// - START without prior STOP is repeated
// - Data changes only while clock low
// - Eight bits MSB first plus acknowledge
// - Receiver acknowledges low on ninth clock
// - Master sends 7-bit address and direction
// - Match acknowledges; mismatch releases and waits
// - One address packet per START
// - Direction low writes, high reads
// - Data packet direction from last address
// - Empty write ends with immediate STOP
// - Master ends write after data NACK
// - Master NACKs last read byte
// - Combined transactions via repeated START
// - Stretch only after seeing clock low
// - Hold clock low during wake-up
// - Stretch per received byte before acknowledge; wake-up waits
// - Master starts idle, yields, retries after STOP
// - Slave ignores arbitration, follows bus
// - Masters time high after clock released
// - Device is slave only
`timescale 1ns/100ps
`default_nettype none
`include "twb_consts.svh"
module twb_slave (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    twb_if.dev              bus,
    input  wire logic [6:0] own_addr_i,
    input  wire logic       asleep_i,
    input  wire logic       hold_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       rx_ack_i,
    output logic            tx_req_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            addr_hit_o,
    output logic            dir_read_o,
    output logic            start_o,
    output logic            rstart_o,
    output logic            stop_o,
    output logic            mst_nack_o,
    output logic            busy_o
);
    typedef struct packed {
        logic [1:0]            scl_sync;
        logic [1:0]            sda_sync;
        logic [1:0]            scl_cnt;
        logic [1:0]            sda_cnt;
        logic                  scl_f;
        logic                  sda_f;
        logic                  stopped;
        twb_pkg::twb_sl_state_t st;
        logic [3:0]            bitn;
        logic [7:0]            shreg;
        logic                  rd;
        logic                  is_addr;
        logic                  sda_oe;
        logic                  scl_oe;
        logic [4:0]            wake;
        logic [7:0]            rx_data;
        logic                  rx_valid;
        logic                  tx_req;
        logic                  hit;
        logic                  start;
        logic                  rstart;
        logic                  stop;
        logic                  mnack;
    } twb_sl_t;

    twb_sl_t s_reg;
    twb_sl_t s_next;

    function automatic logic twb_filt_step(input logic cur, input logic raw,
                                           input logic [1:0] cnt);
        twb_filt_step = (raw != cur && cnt == 2'(`TWB_FILT_CYC - 1)) ? raw : cur;
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;

    always_comb begin
        s_next = s_reg;
        s_next.start = 1'b0;
        s_next.rstart = 1'b0;
        s_next.stop = 1'b0;
        s_next.rx_valid = 1'b0;
        s_next.mnack = 1'b0;
        // ----------------------------------------------------------------
        // Input synchroniser and glitch filter
        // ----------------------------------------------------------------
        s_next.scl_sync = {s_reg.scl_sync[0], bus.scl};
        s_next.sda_sync = {s_reg.sda_sync[0], bus.sda};
        s_next.scl_cnt = (s_reg.scl_sync[1] != s_reg.scl_f) ? s_reg.scl_cnt + 2'h1 : 2'h0;
        s_next.sda_cnt = (s_reg.sda_sync[1] != s_reg.sda_f) ? s_reg.sda_cnt + 2'h1 : 2'h0;
        s_next.scl_f = twb_filt_step(s_reg.scl_f, s_reg.scl_sync[1], s_reg.scl_cnt);
        s_next.sda_f = twb_filt_step(s_reg.sda_f, s_reg.sda_sync[1], s_reg.sda_cnt);
        scl_rise = s_next.scl_f & ~s_reg.scl_f;
        scl_fall = ~s_next.scl_f & s_reg.scl_f;
        sda_rise = s_next.sda_f & ~s_reg.sda_f;
        sda_fall = ~s_next.sda_f & s_reg.sda_f;
        // ----------------------------------------------------------------
        // Protocol sequencer
        // ----------------------------------------------------------------
        if (s_reg.scl_f && s_next.scl_f && sda_fall) begin
            s_next.start = s_reg.stopped;
            s_next.rstart = ~s_reg.stopped;
            s_next.stopped = 1'b0;
            s_next.st = asleep_i ? twb_pkg::SL_WAKE : twb_pkg::SL_ADDR;
            s_next.wake = 5'(`TWB_WAKE_CYC);
            s_next.bitn = 4'h0;
            s_next.sda_oe = 1'b0;
            s_next.is_addr = 1'b1;
            s_next.hit = 1'b0;
        end else if (s_reg.scl_f && s_next.scl_f && sda_rise) begin
            s_next.stop = 1'b1;
            s_next.stopped = 1'b1;
            s_next.st = twb_pkg::SL_IDLE;
            s_next.sda_oe = 1'b0;
            s_next.scl_oe = 1'b0;
            s_next.hit = 1'b0;
        end else begin
            case (s_reg.st)
                twb_pkg::SL_IDLE: begin
                    s_next.sda_oe = 1'b0;
                    s_next.scl_oe = 1'b0;
                end
                twb_pkg::SL_WAKE: begin
                    if (!s_reg.scl_f) begin
                        s_next.scl_oe = 1'b1;
                    end
                    if (s_reg.scl_oe && s_reg.wake != 5'h0) begin
                        s_next.wake = s_reg.wake - 5'h1;
                    end else if (s_reg.scl_oe) begin
                        s_next.scl_oe = 1'b0;
                        s_next.st = twb_pkg::SL_ADDR;
                    end
                end
                twb_pkg::SL_ADDR, twb_pkg::SL_RX: begin
                    if (scl_rise) begin
                        s_next.shreg = {s_reg.shreg[6:0], s_reg.sda_f};
                        s_next.bitn = s_reg.bitn + 4'h1;
                    end
                    if (scl_fall && s_reg.bitn == `TWB_BITS_PER_BYTE) begin
                        if (s_reg.st == twb_pkg::SL_ADDR) begin
                            s_next.hit = (s_reg.shreg[7:1] == own_addr_i);
                            s_next.rd = s_reg.shreg[`TWB_DIR_BIT];
                            s_next.sda_oe = (s_reg.shreg[7:1] == own_addr_i);
                            s_next.st = (s_reg.shreg[7:1] == own_addr_i) ?
                                        twb_pkg::SL_ACK : twb_pkg::SL_IDLE;
                        end else begin
                            s_next.rx_data = s_reg.shreg;
                            s_next.rx_valid = 1'b1;
                            s_next.sda_oe = rx_ack_i;
                            s_next.st = twb_pkg::SL_ACK;
                        end
                        s_next.scl_oe = hold_i & (s_next.st == twb_pkg::SL_ACK);
                    end
                end
                twb_pkg::SL_ACK: begin
                    if (s_reg.scl_oe && !hold_i) begin
                        s_next.scl_oe = 1'b0;
                    end
                    if (scl_rise && !s_reg.sda_oe && s_reg.rd && !s_reg.is_addr) begin
                        s_next.mnack = s_reg.sda_f;
                    end
                    if (scl_fall) begin
                        s_next.bitn = 4'h0;
                        if (s_reg.rd && !(s_reg.sda_f && !s_reg.is_addr)) begin
                            s_next.shreg = {tx_data_i[6:0], 1'b0};
                            s_next.sda_oe = ~tx_data_i[7];
                            s_next.tx_req = 1'b1;
                            s_next.st = twb_pkg::SL_TX;
                        end else if (s_reg.rd) begin
                            s_next.sda_oe = 1'b0;
                            s_next.st = twb_pkg::SL_IDLE;
                        end else begin
                            s_next.sda_oe = 1'b0;
                            s_next.st = twb_pkg::SL_RX;
                        end
                        s_next.is_addr = 1'b0;
                    end
                end
                twb_pkg::SL_TX: begin
                    s_next.tx_req = 1'b0;
                    if (scl_rise) begin
                        s_next.bitn = s_reg.bitn + 4'h1;
                    end
                    if (scl_fall) begin
                        if (s_reg.bitn == `TWB_BITS_PER_BYTE) begin
                            s_next.sda_oe = 1'b0;
                            s_next.st = twb_pkg::SL_ACK;
                        end else begin
                            s_next.sda_oe = ~s_reg.shreg[7];
                            s_next.shreg = {s_reg.shreg[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    s_next.st = twb_pkg::SL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_cnt: 2'h0, sda_cnt: 2'h0,
                       scl_f: 1'b1, sda_f: 1'b1, stopped: 1'b1,
                       st: twb_pkg::SL_IDLE, bitn: 4'h0, shreg: 8'h00, rd: 1'b0,
                       is_addr: 1'b0, sda_oe: 1'b0, scl_oe: 1'b0, wake: 5'h00,
                       rx_data: 8'h00, rx_valid: 1'b0, tx_req: 1'b0, hit: 1'b0,
                       start: 1'b0, rstart: 1'b0, stop: 1'b0, mnack: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // --------------------------------------------------------------------
    // Outputs: open-drain enables only, slave role only
    // --------------------------------------------------------------------
    assign bus.dev_scl_oe = s_reg.scl_oe;
    assign bus.dev_sda_oe = s_reg.sda_oe;
    assign tx_req_o   = s_reg.tx_req;
    assign rx_data_o  = s_reg.rx_data;
    assign rx_valid_o = s_reg.rx_valid;
    assign addr_hit_o = s_reg.hit;
    assign dir_read_o = s_reg.rd;
    assign start_o    = s_reg.start;
    assign rstart_o   = s_reg.rstart;
    assign stop_o     = s_reg.stop;
    assign mst_nack_o = s_reg.mnack;
    assign busy_o     = ~s_reg.stopped;
endmodule
`default_nettype wire

/* common/twb_consts.svh */
// Timing counts and field constants for the two-wire bus ends.
// Assumes a 50 MHz system clock on both ends.
`ifndef TWB_CONSTS_SVH
`define TWB_CONSTS_SVH

`define TWB_CLK_MHZ          50
`define TWB_HALF_NS          2500
`define TWB_HALF_CYC         ((`TWB_HALF_NS * `TWB_CLK_MHZ) / 1000)
`define TWB_FILT_CYC         3
`define TWB_BITS_PER_BYTE    4'h8
`define TWB_ACK_BIT          4'h8
`define TWB_DIR_BIT          0
`define TWB_DEF_ADDR         7'h2A
`define TWB_WAKE_CYC         16

`endif

/* common/twb_pkg.sv */
// Types shared by both two-wire bus ends.
// Assumes twb_consts.svh for numeric values.
package twb_pkg;

    typedef enum logic [5:0] {
        SL_IDLE = 6'h01,
        SL_ADDR = 6'h02,
        SL_RX   = 6'h04,
        SL_TX   = 6'h08,
        SL_ACK  = 6'h10,
        SL_WAKE = 6'h20
    } twb_sl_state_t;

    typedef enum logic [6:0] {
        MS_IDLE  = 7'h01,
        MS_START = 7'h02,
        MS_LOW   = 7'h04,
        MS_HIGH  = 7'h08,
        MS_STOP  = 7'h10,
        MS_STOP2 = 7'h20,
        MS_RSTRT = 7'h40
    } twb_ms_state_t;

endpackage

/* common/twb_if.sv */
// Two-wire bus wires with a pull-up resolving wired-AND levels.
// Assumes one device end and one master end.
`timescale 1ns/100ps
`default_nettype none
interface twb_if;
    logic dev_scl_oe;
    logic dev_sda_oe;
    logic mst_scl_oe;
    logic mst_sda_oe;
    logic scl;
    logic sda;

    assign scl = ~(dev_scl_oe | mst_scl_oe);
    assign sda = ~(dev_sda_oe | mst_sda_oe);

    modport dev (
        input  scl,
        input  sda,
        output dev_scl_oe,
        output dev_sda_oe
    );
    modport mst (
        input  scl,
        input  sda,
        output mst_scl_oe,
        output mst_sda_oe
    );
endinterface
`default_nettype wire

/* hdl/twb_master.sv */
// Two-wire bus master end: one byte per command, clock from a divider.
// Assumes the bus interface resolves open-drain levels with pull-ups.
`timescale 1ns/100ps
`default_nettype none
`include "twb_consts.svh"
module twb_master (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    twb_if.mst              bus,
    input  wire logic       cmd_valid_i,
    input  wire logic       cmd_start_i,
    input  wire logic       cmd_stop_i,
    input  wire logic       cmd_read_i,
    input  wire logic       cmd_ack_i,
    input  wire logic [7:0] cmd_data_i,
    output logic            cmd_ready_o,
    output logic            done_o,
    output logic [7:0]      rd_data_o,
    output logic            ack_seen_o,
    output logic            lost_o
);
    typedef struct packed {
        logic [1:0]             scl_sync;
        logic [2:0]             sda_sync;
        twb_pkg::twb_ms_state_t st;
        logic [7:0]             cnt;
        logic [3:0]             bitn;
        logic [8:0]             sh;
        logic                   rd;
        logic                   stp;
        logic                   own;
        logic                   busy;
        logic                   scl_oe;
        logic                   sda_oe;
        logic                   done;
        logic [7:0]             rdat;
        logic                   ack;
        logic                   lost;
    } twb_ms_t;

    twb_ms_t m_reg;
    twb_ms_t m_next;
    logic    scl_s;
    logic    sda_s;

    always_comb begin
        m_next = m_reg;
        m_next.done = 1'b0;
        m_next.scl_sync = {m_reg.scl_sync[0], bus.scl};
        m_next.sda_sync = {m_reg.sda_sync[1:0], bus.sda};
        scl_s = m_reg.scl_sync[1];
        sda_s = m_reg.sda_sync[1];
        // ----------------------------------------------------------------
        // Bus idle tracking
        // ----------------------------------------------------------------
        if (scl_s && m_reg.sda_sync[2] && !sda_s) begin
            m_next.busy = 1'b1;
        end else if (scl_s && !m_reg.sda_sync[2] && sda_s) begin
            m_next.busy = 1'b0;
        end
        case (m_reg.st)
            twb_pkg::MS_IDLE: begin
                if (cmd_valid_i && cmd_start_i && (!m_reg.busy || m_reg.own)) begin
                    m_next.st = m_reg.own ? twb_pkg::MS_RSTRT : twb_pkg::MS_START;
                    m_next.cnt = 8'h00;
                end else if (cmd_valid_i && m_reg.own) begin
                    m_next.st = twb_pkg::MS_LOW;
                    m_next.cnt = 8'h00;
                end
                m_next.rd = cmd_read_i;
                m_next.stp = cmd_stop_i;
                m_next.sh = cmd_read_i ? {8'hFF, ~cmd_ack_i} : {cmd_data_i, 1'b1};
                m_next.bitn = 4'h0;
            end
            twb_pkg::MS_RSTRT: begin
                m_next.sda_oe = 1'b0;
                m_next.scl_oe = (m_reg.cnt < 8'(`TWB_HALF_CYC));
                if (scl_s || m_reg.cnt < 8'(`TWB_HALF_CYC)) begin
                    m_next.cnt = m_reg.cnt + 8'h01;
                end
                if (m_reg.cnt == 8'(2 * `TWB_HALF_CYC)) begin
                    m_next.st = twb_pkg::MS_START;
                    m_next.cnt = 8'h00;
                end
            end
            twb_pkg::MS_START: begin
                m_next.sda_oe = 1'b1;
                m_next.own = 1'b1;
                m_next.cnt = m_reg.cnt + 8'h01;
                if (m_reg.cnt == 8'(`TWB_HALF_CYC)) begin
                    m_next.scl_oe = 1'b1;
                    m_next.st = twb_pkg::MS_LOW;
                    m_next.cnt = 8'h00;
                end
            end
            twb_pkg::MS_LOW: begin
                m_next.scl_oe = 1'b1;
                m_next.cnt = m_reg.cnt + 8'h01;
                if (m_reg.cnt == 8'h02) begin
                    m_next.sda_oe = ~m_reg.sh[8];
                end
                if (m_reg.cnt == 8'(`TWB_HALF_CYC)) begin
                    m_next.scl_oe = 1'b0;
                    m_next.st = twb_pkg::MS_HIGH;
                    m_next.cnt = 8'h00;
                end
            end
            twb_pkg::MS_HIGH: begin
                if (scl_s) begin
                    m_next.cnt = m_reg.cnt + 8'h01;
                end
                if (scl_s && m_reg.cnt == 8'h00) begin
                    m_next.sh = {m_reg.sh[7:0], sda_s};
                    if (!m_reg.sda_oe && !sda_s && !(m_reg.rd && m_reg.bitn != `TWB_ACK_BIT)
                        && m_reg.bitn != `TWB_ACK_BIT) begin
                        m_next.lost = 1'b1;
                        m_next.own = 1'b0;
                        m_next.sda_oe = 1'b0;
                        m_next.scl_oe = 1'b0;
                        m_next.st = twb_pkg::MS_IDLE;
                    end
                end
                if (m_reg.cnt == 8'(`TWB_HALF_CYC) && m_reg.st == twb_pkg::MS_HIGH) begin
                    m_next.cnt = 8'h00;
                    if (m_reg.bitn == `TWB_ACK_BIT) begin
                        m_next.done = 1'b1;
                        m_next.rdat = m_reg.sh[8:1];
                        m_next.ack = ~m_reg.sh[0];
                        m_next.scl_oe = 1'b1;
                        m_next.st = (m_reg.stp || (!m_reg.rd && m_reg.sh[0])) ?
                                    twb_pkg::MS_STOP : twb_pkg::MS_IDLE;
                    end else begin
                        m_next.bitn = m_reg.bitn + 4'h1;
                        m_next.scl_oe = 1'b1;
                        m_next.st = twb_pkg::MS_LOW;
                    end
                end
            end
            twb_pkg::MS_STOP: begin
                m_next.scl_oe = 1'b1;
                m_next.sda_oe = 1'b1;
                m_next.cnt = m_reg.cnt + 8'h01;
                if (m_reg.cnt == 8'(`TWB_HALF_CYC)) begin
                    m_next.scl_oe = 1'b0;
                    m_next.st = twb_pkg::MS_STOP2;
                    m_next.cnt = 8'h00;
                end
            end
            twb_pkg::MS_STOP2: begin
                if (scl_s) begin
                    m_next.cnt = m_reg.cnt + 8'h01;
                end
                if (m_reg.cnt == 8'(`TWB_HALF_CYC)) begin
                    m_next.sda_oe = 1'b0;
                    m_next.own = 1'b0;
                    m_next.st = twb_pkg::MS_IDLE;
                end
            end
            default: begin
                m_next.st = twb_pkg::MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            m_reg <= '{scl_sync: 2'h3, sda_sync: 3'h7, st: twb_pkg::MS_IDLE,
                       cnt: 8'h00, bitn: 4'h0, sh: 9'h000, rd: 1'b0, stp: 1'b0,
                       own: 1'b0, busy: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0,
                       done: 1'b0, rdat: 8'h00, ack: 1'b0, lost: 1'b0};
        end else begin
            m_reg <= m_next;
        end
    end

    assign bus.mst_scl_oe = m_reg.scl_oe;
    assign bus.mst_sda_oe = m_reg.sda_oe;
    assign cmd_ready_o = (m_reg.st == twb_pkg::MS_IDLE) && !(cmd_start_i && m_reg.busy && !m_reg.own);
    assign done_o      = m_reg.done;
    assign rd_data_o   = m_reg.rdat;
    assign ack_seen_o  = m_reg.ack;
    assign lost_o      = m_reg.lost;
endmodule
`default_nettype wire

/* test/twb_chk_sva.sv */
// Assertions on the two-wire bus lines between the slave and master ends.
// Assumes the lines are sampled on the system clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
module twb_chk (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic dev_scl_oe,
    input  wire logic dev_sda_oe,
    input  wire logic mst_scl_oe,
    input  wire logic mst_sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    // ----------------------------------------
    // Bit and packet tracking
    // ----------------------------------------
    logic       sq_reg, dq_reg, first_reg, rd_reg, busy_reg;
    logic [3:0] bit_reg;
    logic       hi, start_seen, stop_seen;
    assign hi         = scl & sq_reg;
    assign start_seen = hi & dq_reg & ~sda;
    assign stop_seen  = hi & ~dq_reg & sda;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {sq_reg, dq_reg, first_reg, rd_reg, busy_reg} <= 5'h18;
            bit_reg <= 4'h0;
        end else begin
            sq_reg <= scl;
            dq_reg <= sda;
            if (start_seen) begin
                {bit_reg, first_reg, busy_reg} <= {4'h0, 1'b1, 1'b1};
            end else if (stop_seen) begin
                busy_reg <= 1'b0;
            end else if (scl & ~sq_reg) begin
                bit_reg <= (bit_reg == 4'h9) ? 4'h1 : bit_reg + 4'h1;
                if (bit_reg == 4'h9) first_reg <= 1'b0;
                if (first_reg && bit_reg == 4'h7) rd_reg <= sda;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_DEV_SDA_STABLE: assert property (hi |-> $stable(dev_sda_oe))
        else $error("slave data changed while clock high");
    AST_DEV_STRETCH_AFTER_LOW: assert property ($rose(dev_scl_oe) |-> !$past(scl))
        else $error("slave stretch began on a high clock");
    AST_ADDR_FROM_MASTER: assert property (hi && first_reg && bit_reg inside {[1:8]} |-> !dev_sda_oe)
        else $error("slave drove data in address bits");
    AST_WR_DEV_QUIET: assert property (hi && !first_reg && !rd_reg && bit_reg inside {[1:8]}
        |-> !dev_sda_oe) else $error("slave drove data bits in a write");
    AST_RD_DEV_NO_ACK: assert property (hi && !first_reg && rd_reg && bit_reg == 4'h9
        |-> !dev_sda_oe) else $error("slave drove acknowledge of its own byte");
    AST_RD_MST_QUIET: assert property (hi && !first_reg && rd_reg && bit_reg inside {[2:8]}
        |-> !mst_sda_oe) else $error("master drove data bits in a read");
    AST_ACK_MST_QUIET: assert property (hi && bit_reg == 4'h9 && (first_reg || !rd_reg)
        |-> !mst_sda_oe) else $error("master drove its own acknowledge");
    AST_IDLE_DEV_QUIET: assert property (!busy_reg |-> !dev_sda_oe && !dev_scl_oe)
        else $error("slave drove an idle bus");
    CVR_RSTART: cover property (start_seen && busy_reg);
    CVR_RD_NACK: cover property (hi && !first_reg && rd_reg && bit_reg == 4'h9 && sda);
    CVR_STRETCH: cover property ($rose(dev_scl_oe) && !mst_scl_oe);
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench: master end drives the slave end over the bus.
// Assumes the shared constants header and a 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "twb_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    logic       clk_i = 1'b0, nrst_i = 1'b0, asleep_i = 1'b0, hold_i = 1'b0, rx_ack_i = 1'b1;
    logic [6:0] own_addr_i = `TWB_DEF_ADDR;
    logic [7:0] tx_data_i = 8'h00, cmd_data_i = 8'h00, rx_data_o, rd_data_o, b;
    logic       cmd_valid_i = 1'b0, cmd_start_i = 1'b0, cmd_stop_i = 1'b0;
    logic       cmd_read_i = 1'b0, cmd_ack_i = 1'b0;
    logic       tx_req_o, rx_valid_o, addr_hit_o, dir_read_o, start_o, rstart_o, stop_o;
    logic       mst_nack_o, busy_o, cmd_ready_o, done_o, ack_seen_o, lost_o;
    logic [7:0] txq [4];
    logic [8:0] wsh = 9'h000;
    int         num_errors = 0, total_checks = 0, seed = 32'hC1F7, cyc = 0;
    int         nstop = 0, nrs = 0, nnack = 0, run = 0, maxrun = 0, tidx = 0;
    twb_if twb_if_inst ();
    twb_slave twb_slave_inst (.clk_i, .nrst_i, .bus(twb_if_inst.dev), .own_addr_i, .asleep_i,
        .hold_i, .tx_data_i, .rx_ack_i, .tx_req_o, .rx_data_o, .rx_valid_o, .addr_hit_o,
        .dir_read_o, .start_o, .rstart_o, .stop_o, .mst_nack_o, .busy_o);
    twb_master twb_master_inst (.clk_i, .nrst_i, .bus(twb_if_inst.mst), .cmd_valid_i,
        .cmd_start_i, .cmd_stop_i, .cmd_read_i, .cmd_ack_i, .cmd_data_i, .cmd_ready_o,
        .done_o, .rd_data_o, .ack_seen_o, .lost_o);
    twb_chk twb_chk_inst (.clk_i, .nrst_i, .dev_scl_oe(twb_if_inst.dev_scl_oe),
        .dev_sda_oe(twb_if_inst.dev_sda_oe), .mst_scl_oe(twb_if_inst.mst_scl_oe),
        .mst_sda_oe(twb_if_inst.mst_sda_oe), .scl(twb_if_inst.scl), .sda(twb_if_inst.sda));
    // ----------------------------------------
    // Clock, monitors and timeout
    // ----------------------------------------
    always #10 clk_i = ~clk_i;
    always @(posedge twb_if_inst.scl) wsh <= {wsh[7:0], twb_if_inst.sda};
    always @(posedge clk_i) begin
        cyc++;
        nstop += stop_o;
        nrs += rstart_o;
        nnack += mst_nack_o;
        hold_i <= #1 (($random(seed) & 15) == 0);
        if (tx_req_o === 1'b1) begin
            tidx++;
            tx_data_i <= #1 txq[tidx[1:0]];
        end
        run = twb_if_inst.dev_scl_oe ? run + 1 : 0;
        if (run > maxrun) maxrun = run;
        if (cyc > 80000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic xfer(input logic s, p, r, a, ra, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        #1;
        {cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i, rx_ack_i} = {s, p, r, a, ra};
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        n = 0;
        do begin @(negedge clk_i); n++; end while (cmd_ready_o !== 1'b1 && n < 3000);
        @(posedge clk_i);
        #1 cmd_valid_i = 1'b0;
        do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 9000);
        if (n >= 9000) num_errors++;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin @(negedge clk_i); n++; end while (busy_o !== 1'b0 && n < 3000);
        if (n >= 3000) num_errors++;
        @(negedge clk_i);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) txq[i] = 8'($random(seed));
        repeat (3) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        xfer(1, 1, 0, 0, 1, {`TWB_DEF_ADDR, 1'b0});
        `CHK("addr ack", 1'b1, ack_seen_o)
        `CHK("dir", 1'b0, dir_read_o)
        wait_idle();
        `CHK("stops", 1, nstop)
        `CHK("idle lines", 2'h3, {twb_if_inst.scl, twb_if_inst.sda})
        xfer(1, 0, 0, 0, 1, {`TWB_DEF_ADDR, 1'b0});
        for (int k = 0; k < 4; k++) begin
            b = 8'($random(seed));
            xfer(0, k == 3, 0, 0, k != 3, b);
            `CHK("rx byte", b, rx_data_o)
            `CHK("wire bits", {b, k == 3}, wsh)
            `CHK("byte ack", k != 3, ack_seen_o)
        end
        wait_idle();
        @(posedge clk_i);
        #1 asleep_i = 1'b1;
        maxrun = 0;
        xfer(1, 1, 0, 0, 1, {`TWB_DEF_ADDR ^ 7'h01, 1'b0});
        `CHK("miss ack", 1'b0, ack_seen_o)
        `CHK("miss hit", 1'b0, addr_hit_o)
        `CHK("wake hold", 1'b1, maxrun >= `TWB_WAKE_CYC)
        wait_idle();
        @(posedge clk_i);
        #1 asleep_i = 1'b0;
        tidx = 0;
        tx_data_i = txq[0];
        xfer(1, 0, 0, 0, 1, {`TWB_DEF_ADDR, 1'b1});
        `CHK("dir", 1'b1, dir_read_o)
        for (int k = 0; k < 3; k++) begin
            xfer(0, k == 2, 1, k != 2, 1, 8'h00);
            `CHK("rd byte", txq[k], rd_data_o)
        end
        wait_idle();
        `CHK("master nacks", 1, nnack)
        xfer(1, 0, 0, 0, 1, {`TWB_DEF_ADDR, 1'b0});
        b = 8'($random(seed));
        xfer(0, 0, 0, 0, 1, b);
        `CHK("rx byte", b, rx_data_o)
        tidx = 0;
        tx_data_i = txq[0];
        xfer(1, 0, 0, 0, 1, {`TWB_DEF_ADDR, 1'b1});
        `CHK("rstarts", 1, nrs)
        xfer(0, 1, 1, 0, 1, 8'h00);
        `CHK("rd byte", txq[0], rd_data_o)
        wait_idle();
        `CHK("busy", 1'b0, busy_o)
        `CHK("lost", 1'b0, lost_o)
        stop_test();
    end
endmodule
`default_nettype wire
